// ---- rtl/plre_regs.sv ----
// power management and link enhancement configuration registers
//
// Overview of operation
// - power registers survive internal sleep-exit reset
// - wake status sets on wake cause always
// - clearing wake status releases wake output
// - dynamic data control bits read zero
// - wake enable gates wake output
// - dynamic data bit reads zero
// - two-bit device power state field
// - extension register at 4Ah reads zero
// - power data and bridge bytes zero
// - enhancement bits loaded by software or memory
// - enhancements act only when enabled
// - unfair bit sends responses as priority
// - one idle cycle before hold/transmit
// - acceleration bit issues acceleration requests
// - cancel request once receive exceeds 8 bits
// - F8h aliases subsystem ident at 2Ch
// - subsystem ident is writable, two fields
`default_nettype none
module plre_regs
  import plre_pkg::*;
(
  // clock and resets
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic int_rst_i,
  // configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  // serial configuration memory load
  input wire logic eeprom_ld_i,
  input wire logic [31:0] eeprom_data_i,
  // core control and events
  input wire logic phy_enhancements_on_i,
  input wire logic wake_cause_i,
  input wire logic async_resp_i,
  input wire logic accel_change_i,
  input wire logic accel_on_i,
  // link pins
  input wire logic grant_i,
  input wire logic [1:0] ctl_i,
  input wire logic want_xmit_i,
  output logic [1:0] ctl_o,
  output logic ctl_oe_n_o,
  output logic lreq_cancel_o,
  output logic priority_req_o,
  output logic accel_req_o,
  output logic accel_req_on_o,
  // power
  output logic wake_n_o,
  output logic [1:0] device_power_state_o
);
  // ==========================================================
  // pin synchronisers
  logic grant_s1_r, grant_s2_r;
  logic [1:0] ctl_s1_r, ctl_s2_r;

  // phy pins run on another clock: two flops before any logic reads them
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_s1_r <= 1'b0;
      grant_s2_r <= 1'b0;
      ctl_s1_r <= 2'h0;
      ctl_s2_r <= 2'h0;
    end else begin
      grant_s1_r <= grant_i;
      grant_s2_r <= grant_s1_r;
      ctl_s1_r <= ctl_i;
      ctl_s2_r <= ctl_s1_r;
    end
  end

  // ==========================================================
  // power management control/status
  // kept on rst_i only; the internal reset must not touch it
  logic wake_sts_r, wake_sts_nxt;
  logic wake_en_r, wake_en_nxt;
  logic [1:0] pstate_r, pstate_nxt;
  logic wake_n_r, wake_n_nxt;
  logic pm_wr;

  assign pm_wr = cfg_wr_i && cfg_addr_i == PLRE_OFF_PM;

  always_comb begin
    wake_sts_nxt = wake_sts_r;
    wake_en_nxt = wake_en_r;
    pstate_nxt = pstate_r;
    if (pm_wr && cfg_be_i[1] && cfg_wdata_i[PLRE_PM_WAKE_STS]) wake_sts_nxt = 1'b0;
    if (wake_cause_i) wake_sts_nxt = 1'b1;
    if (pm_wr && cfg_be_i[1]) wake_en_nxt = cfg_wdata_i[PLRE_PM_WAKE_EN];
    if (pm_wr && cfg_be_i[0]) pstate_nxt = cfg_wdata_i[PLRE_PM_STATE_LO +: 2];
    // wake pin follows the sticky status, gated by the enable
    wake_n_nxt = !(wake_sts_nxt && wake_en_nxt);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_sts_r <= PLRE_PM_RESET[PLRE_PM_WAKE_STS];
      wake_en_r <= PLRE_PM_RESET[PLRE_PM_WAKE_EN];
      pstate_r <= PLRE_PM_RESET[1:0];
      wake_n_r <= 1'b1;
    end else begin
      wake_sts_r <= wake_sts_nxt;
      wake_en_r <= wake_en_nxt;
      pstate_r <= pstate_nxt;
      wake_n_r <= wake_n_nxt;
    end
  end

  a_wen_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pm_wr && cfg_be_i[1] && cfg_wdata_i[PLRE_PM_WAKE_EN]) |=> wake_en_r)
    else $error("wake enable not set by write");
  a_wen_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pm_wr && cfg_be_i[1] && !cfg_wdata_i[PLRE_PM_WAKE_EN]) |=> !wake_en_r)
    else $error("wake enable not cleared by write");
  a_state_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pm_wr && cfg_be_i[0]) |=> device_power_state_o == 2'($past(cfg_wdata_i) >> PLRE_PM_STATE_LO))
    else $error("power state not written");
  a_wake_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wake_n_o == !(wake_sts_r && wake_en_r))
    else $error("wake pin does not follow status and enable");
  a_sts_keep_be: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wake_sts_r && pm_wr && !cfg_be_i[1]) |=> wake_sts_r)
    else $error("wake status cleared without its byte enabled");

  // ==========================================================
  // link enhancement and subsystem ident (cleared by both resets)
  logic [31:0] le_r, le_nxt;
  logic [31:0] ssid_r, ssid_nxt;
  logic le_wr, ssid_wr;

  assign le_wr = cfg_wr_i && cfg_addr_i == PLRE_OFF_LINK;
  assign ssid_wr = cfg_wr_i && (cfg_addr_i == PLRE_OFF_SSID || cfg_addr_i == PLRE_OFF_SSID_ALIAS);

  always_comb begin
    le_nxt = le_r;
    ssid_nxt = ssid_r;
    // a memory load wins over a config write landing in the same cycle
    if (eeprom_ld_i) le_nxt = eeprom_data_i & PLRE_LE_WMASK;
    else if (le_wr && cfg_be_i[0]) le_nxt = cfg_wdata_i & PLRE_LE_WMASK;
    for (int b = 0; b < 4; b++) begin
      if (ssid_wr && cfg_be_i[b]) ssid_nxt[8*b +: 8] = cfg_wdata_i[8*b +: 8];
    end
    if (int_rst_i) begin
      le_nxt = PLRE_LE_RESET;
      ssid_nxt = PLRE_SSID_RESET;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      le_r <= PLRE_LE_RESET;
      ssid_r <= PLRE_SSID_RESET;
    end else begin
      le_r <= le_nxt;
      ssid_r <= ssid_nxt;
    end
  end

  a_le_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (le_wr && cfg_be_i[0] && !eeprom_ld_i && !int_rst_i) |=>
      le_r == ($past(cfg_wdata_i) & PLRE_LE_WMASK))
    else $error("enhancement write not taken");
  a_le_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (eeprom_ld_i && !int_rst_i) |=> le_r == ($past(eeprom_data_i) & PLRE_LE_WMASK))
    else $error("enhancement load not taken");
  a_ssid_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ssid_wr && cfg_be_i == 4'hf && !int_rst_i) |=> ssid_r == $past(cfg_wdata_i))
    else $error("subsystem ident write not taken");

  // ==========================================================
  // enhancement behaviour
  // stored bits alone do nothing: the host gate must be on as well
  logic unfair_on, idle_on, accel_on;
  logic acc_req_r, acc_req_nxt, acc_on_r, acc_on_nxt, prio_r, prio_nxt;

  assign unfair_on = phy_enhancements_on_i && le_r[PLRE_LE_UNFAIR];
  assign idle_on = phy_enhancements_on_i && le_r[PLRE_LE_IDLE];
  assign accel_on = phy_enhancements_on_i && le_r[PLRE_LE_ACCEL];

  always_comb begin
    prio_nxt = async_resp_i && unfair_on;
    acc_req_nxt = accel_change_i && accel_on;
    acc_on_nxt = acc_req_nxt ? accel_on_i : acc_on_r;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_r <= 1'b0;
      acc_req_r <= 1'b0;
      acc_on_r <= 1'b0;
    end else begin
      prio_r <= prio_nxt;
      acc_req_r <= acc_req_nxt;
      acc_on_r <= acc_on_nxt;
    end
  end

  a_enh_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !phy_enhancements_on_i |=> (!priority_req_o && !accel_req_o))
    else $error("enhancement active while gate off");
  a_unfair_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !le_r[PLRE_LE_UNFAIR] |=> !priority_req_o)
    else $error("priority request without unfair bit");
  a_accel_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (accel_change_i && accel_on) |=> (accel_req_o && accel_req_on_o == $past(accel_on_i)))
    else $error("acceleration request missing or wrong");

  plre_link_enh #(
    .CNT_W(4)
  ) u_link (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .idle_en_i(idle_on),
    .accel_en_i(accel_on),
    .grant_i(grant_s2_r),
    .ctl_in_i(ctl_s2_r),
    .want_xmit_i(want_xmit_i),
    .ctl_out_o(ctl_o),
    .ctl_oe_n_o(ctl_oe_n_o),
    .lreq_cancel_o(lreq_cancel_o)
  );

  // ==========================================================
  // read mux
  // read data is registered and stands for one cycle only
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        // upper half is the extension register: always zero
        PLRE_OFF_PM: begin
          rdata_nxt[PLRE_PM_WAKE_STS] = wake_sts_r;
          rdata_nxt[PLRE_PM_WAKE_EN] = wake_en_r;
          rdata_nxt[1:0] = pstate_r;
        end
        PLRE_OFF_PMX: rdata_nxt = 32'h0000_0000;
        PLRE_OFF_LINK: rdata_nxt = le_r;
        PLRE_OFF_SSID, PLRE_OFF_SSID_ALIAS: rdata_nxt = ssid_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) rdata_r <= 32'h0000_0000;
    else rdata_r <= rdata_nxt;
  end

  assign cfg_rdata_o = rdata_r;
  assign wake_n_o = wake_n_r;
  assign device_power_state_o = pstate_r;
  assign priority_req_o = prio_r;
  assign accel_req_o = acc_req_r;
  assign accel_req_on_o = acc_on_r;

  // ==========================================================
  // checks
  a_wake_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wake_cause_i |=> wake_sts_r)
    else $error("wake status not set by cause");
  a_wake_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pm_wr && cfg_be_i[1] && cfg_wdata_i[PLRE_PM_WAKE_STS] && !wake_cause_i) |=>
      (!wake_sts_r && wake_n_o))
    else $error("wake clear did not release pin");
  a_wake_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wake_sts_r && !(pm_wr && cfg_wdata_i[15])) |=> wake_sts_r)
    else $error("wake status lost");
  a_wake_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !wake_en_r |-> wake_n_o)
    else $error("wake asserted while disabled");
  a_pm_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (int_rst_i && !pm_wr && !wake_cause_i) |=> $stable(pstate_r) && $stable(wake_en_r))
    else $error("power state lost on internal reset");
  a_alias_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_rd_i && cfg_addr_i == PLRE_OFF_SSID_ALIAS && !ssid_wr && !int_rst_i) |=>
      cfg_rdata_o == ssid_r)
    else $error("alias read mismatch");
  a_ext_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_rd_i && cfg_addr_i == 8'h4a) |=> cfg_rdata_o == 32'h0000_0000)
    else $error("extension register not zero");
  a_prio_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (async_resp_i && phy_enhancements_on_i && le_r[7]) |=> priority_req_o)
    else $error("priority request missing");
  a_accel_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (accel_change_i && !(phy_enhancements_on_i && le_r[PLRE_LE_ACCEL])) |=> !accel_req_o)
    else $error("acceleration request while disabled");

  a_pm_rd_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_rd_i && cfg_addr_i == PLRE_OFF_PM) |=> (cfg_rdata_o & 32'hffff_7efc) == 32'h0000_0000)
    else $error("reserved power bits not zero");
  a_ssid_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_rd_i && cfg_addr_i == PLRE_OFF_SSID && !ssid_wr && !int_rst_i) |=> cfg_rdata_o == ssid_r)
    else $error("subsystem ident read mismatch");
  a_le_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_rd_i && cfg_addr_i == PLRE_OFF_LINK && !le_wr && !eeprom_ld_i && !int_rst_i) |=>
      cfg_rdata_o == le_r)
    else $error("enhancement read mismatch");
  a_pmx_readonly: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_wr_i && cfg_addr_i == PLRE_OFF_PMX) |=> ($stable(pstate_r) && $stable(wake_en_r)))
    else $error("extension write changed power state");
endmodule
`default_nettype wire

// ---- rtl/plre_pkg.sv ----
// package: offsets, field positions, reset values, cancel threshold and line codes for the power and link regs
`default_nettype none
package plre_pkg;
  // configuration byte offsets
  localparam logic [7:0] PLRE_OFF_PM = 8'h48;
  localparam logic [7:0] PLRE_OFF_PMX = 8'h4a;
  localparam logic [7:0] PLRE_OFF_LINK = 8'hf4;
  localparam logic [7:0] PLRE_OFF_SSID = 8'hf8;
  localparam logic [7:0] PLRE_OFF_SSID_ALIAS = 8'h2c;
  // power management control/status fields
  localparam int PLRE_PM_WAKE_STS = 15;
  localparam int PLRE_PM_WAKE_EN = 8;
  localparam int PLRE_PM_STATE_LO = 0;
  localparam logic [15:0] PLRE_PM_RESET = 16'h0000;
  // link enhancement fields
  localparam int PLRE_LE_UNFAIR = 7;
  localparam int PLRE_LE_IDLE = 2;
  localparam int PLRE_LE_ACCEL = 1;
  localparam logic [31:0] PLRE_LE_WMASK = 32'h0000_0086;
  localparam logic [31:0] PLRE_LE_RESET = 32'h0000_0000;
  localparam logic [31:0] PLRE_SSID_RESET = 32'h0000_0000;
  // received bits beyond which a pending link request is cancelled
  localparam int PLRE_RX_CANCEL_BITS = 8;
  // link control line codes
  localparam logic [1:0] PLRE_CTL_IDLE = 2'h0;
  localparam logic [1:0] PLRE_CTL_HOLD = 2'h2;
  localparam logic [1:0] PLRE_CTL_XMIT = 2'h1;
  localparam logic [1:0] PLRE_CTL_RECV = 2'h2;
  typedef enum logic [1:0] {
    PLRE_D0 = 2'h0,
    PLRE_D1 = 2'h1,
    PLRE_D2 = 2'h2,
    PLRE_D3HOT = 2'h3
  } plre_pwr_t;
endpackage
`default_nettype wire

// ---- rtl/plre_link_enh.sv ----
// link-side enhancement logic: idle insertion on grant and receive-length cancel
`default_nettype none
module plre_link_enh
  import plre_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // enables, already qualified
  input wire logic idle_en_i,
  input wire logic accel_en_i,
  // link side, grant and control synchronised
  input wire logic grant_i,
  input wire logic [1:0] ctl_in_i,
  input wire logic want_xmit_i,
  // outputs
  output logic [1:0] ctl_out_o,
  output logic ctl_oe_n_o,
  output logic lreq_cancel_o
);
  // ==========================================================
  // grant sequencing
  typedef enum logic [1:0] {
    PLRE_S_WAIT = 2'b00,
    PLRE_S_IDLE = 2'b01,
    PLRE_S_OWN = 2'b11
  } plre_gst_t;
  plre_gst_t st_r, st_nxt;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
  logic cancel_r, cancel_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      PLRE_S_WAIT: if (grant_i) st_nxt = idle_en_i ? PLRE_S_IDLE : PLRE_S_OWN;
      PLRE_S_IDLE: st_nxt = PLRE_S_OWN;
      PLRE_S_OWN: if (!want_xmit_i) st_nxt = PLRE_S_WAIT;
      default: st_nxt = PLRE_S_WAIT;
    endcase
  end

  // counts received bits in pairs; saturates so it never wraps back below the limit
  always_comb begin
    rx_cnt_nxt = rx_cnt_r;
    cancel_nxt = 1'b0;
    if (ctl_in_i == PLRE_CTL_RECV && st_r == PLRE_S_WAIT) begin
      if (rx_cnt_r != {CNT_W{1'b1}}) rx_cnt_nxt = rx_cnt_r + CNT_W'(1);
    end else begin
      rx_cnt_nxt = '0;
    end
    if (accel_en_i && (32'(rx_cnt_r) * 2 > PLRE_RX_CANCEL_BITS)) cancel_nxt = 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= PLRE_S_WAIT;
      rx_cnt_r <= '0;
      cancel_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      cancel_r <= cancel_nxt;
    end
  end

  assign ctl_out_o = (st_r == PLRE_S_OWN) ? (want_xmit_i ? PLRE_CTL_XMIT : PLRE_CTL_HOLD)
                                          : PLRE_CTL_IDLE;
  assign ctl_oe_n_o = (st_r == PLRE_S_WAIT);
  assign lreq_cancel_o = cancel_r;

  a_idle_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_r == PLRE_S_IDLE) |-> (ctl_out_o == PLRE_CTL_IDLE && !ctl_oe_n_o)
      ##1 (st_r == PLRE_S_OWN))
    else $error("idle insertion not exactly one cycle");
  a_grant_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_r == PLRE_S_WAIT && grant_i && idle_en_i) |=> (st_r == PLRE_S_IDLE))
    else $error("grant did not start idle insertion");
  a_cancel_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(accel_en_i) |-> !lreq_cancel_o)
    else $error("cancel without acceleration");
endmodule
`default_nettype wire

// ---- rtl/_unused_end.sv ----
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// ---- test/plre_phy_model.sv ----
// far-side physical layer model: grant pulse and receive frames on the control lines
`default_nettype none
module plre_phy_model
  import plre_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // bench commands
  input wire logic grant_go_i,
  input wire logic rx_go_i,
  input wire logic [3:0] rx_len_i,
  // link side
  output logic grant_o,
  output logic [1:0] ctl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int rx_left;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_o <= 1'b0;
      ctl_o <= PLRE_CTL_IDLE;
      rx_left <= 0;
    end else begin
      grant_o <= grant_go_i;
      if (rx_go_i) begin
        rx_left <= int'(rx_len_i);
      end else if (rx_left > 0) begin
        rx_left <= rx_left - 1;
      end
      // frame of rx_len cycles, two bits each, idle outside frames
      ctl_o <= (rx_go_i || rx_left > 1) ? PLRE_CTL_RECV : PLRE_CTL_IDLE;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_pci_power_and_link_enhance_regs.sv ----
// self-checking bench for the power and link enhancement registers
`default_nettype none
module tb_pci_power_and_link_enhance_regs
  import plre_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, irst, wr, rd, ld, enh, wcause, aresp, achg, aon, want, ggo, rgo;
  logic grant, oe_n, cancel, prio, areq, areq_on, wake_n;
  logic [7:0] addr;
  logic [3:0] be, rlen;
  logic [31:0] wdata, rdata, eedat, m_le, m_ss;
  logic [1:0] ctl_out, phy_ctl, pstate, m_state, c0, c1;
  logic m_wen, m_wsts;
  wire logic [1:0] ctl_w = oe_n ? phy_ctl : ctl_out;
  int err_total, samples_checked, n_prio, n_areq, n_cancel, drv;
  integer seed;
  plre_regs u_dut (.core_clk_i(clk), .rst_i(rst), .int_rst_i(irst), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .eeprom_ld_i(ld), .eeprom_data_i(eedat),
    .phy_enhancements_on_i(enh), .wake_cause_i(wcause), .async_resp_i(aresp),
    .accel_change_i(achg), .accel_on_i(aon), .grant_i(grant), .ctl_i(ctl_w),
    .want_xmit_i(want), .ctl_o(ctl_out), .ctl_oe_n_o(oe_n), .lreq_cancel_o(cancel),
    .priority_req_o(prio), .accel_req_o(areq), .accel_req_on_o(areq_on),
    .wake_n_o(wake_n), .device_power_state_o(pstate));
  plre_phy_model u_phy (.core_clk_i(clk), .rst_i(rst), .grant_go_i(ggo), .rx_go_i(rgo),
    .rx_len_i(rlen), .grant_o(grant), .ctl_o(phy_ctl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========
  // event monitors
  always @(posedge clk) begin
    if (prio === 1'b1) n_prio++;
    if (areq === 1'b1) n_areq++;
    if (cancel === 1'b1) n_cancel++;
    if (oe_n === 1'b0) begin
      if (drv == 0) c0 = ctl_out;
      if (drv == 1) c1 = ctl_out;
      drv++;
    end else drv = 0;
  end
  // ==========
  // model and tasks
  function automatic logic [31:0] m_read(input logic [7:0] a);
    case (a)
      PLRE_OFF_PM: m_read = {16'h0, m_wsts, 6'h0, m_wen, 6'h0, m_state};
      PLRE_OFF_LINK: m_read = m_le;
      PLRE_OFF_SSID, PLRE_OFF_SSID_ALIAS: m_read = m_ss;
      default: m_read = 32'h0;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    tick(1);
    {wr, addr, be, wdata} = {1'b1, a, b, d};
    tick(1);
    wr = 1'b0;
    if (a == PLRE_OFF_PM && b[0]) m_state = d[1:0];
    if (a == PLRE_OFF_PM && b[1]) begin
      m_wen = d[8];
      if (d[15]) m_wsts = 1'b0;
    end
    if (a == PLRE_OFF_LINK && b[0]) m_le = d & PLRE_LE_WMASK;
    for (int k = 0; k < 4; k++)
      if ((a == PLRE_OFF_SSID || a == PLRE_OFF_SSID_ALIAS) && b[k]) m_ss[k*8+:8] = d[k*8+:8];
  endtask
  task automatic rd_reg(input logic [7:0] a);
    tick(1);
    {rd, addr} = {1'b1, a};
    tick(1);
    rd = 1'b0;
    check(rdata, m_read(a));
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // ==========
  // main sequence
  initial begin
    seed = 32'hd7c90023;
    {rst, irst, wr, rd, ld, enh, wcause, aresp, achg, aon, want, ggo, rgo} = 13'h1000;
    {addr, be, rlen, wdata, eedat} = '0;
    {m_le, m_ss, m_state, m_wen, m_wsts} = '0;
    tick(16);
    rst = 1'b0;
    rd_reg(PLRE_OFF_PM);
    rd_reg(PLRE_OFF_PMX);
    rd_reg(PLRE_OFF_LINK);
    rd_reg(PLRE_OFF_SSID);
    rd_reg(8'h44);
    for (int s = 0; s < 4; s++) begin
      wr_reg(PLRE_OFF_PM, 4'h3, ($random(seed) & 32'h0000_7ffc) | s);
      rd_reg(PLRE_OFF_PM);
      check(pstate, m_state);
    end
    wr_reg(PLRE_OFF_PM, 4'h3, 32'h0);
    wcause = 1'b1;
    tick(1);
    wcause = 1'b0;
    m_wsts = 1'b1;
    tick(3);
    check(wake_n, 1'b1);
    rd_reg(PLRE_OFF_PM);
    wr_reg(PLRE_OFF_PM, 4'h3, 32'h0100);
    rd_reg(PLRE_OFF_PM);
    tick(3);
    check(wake_n, 1'b0);
    wr_reg(PLRE_OFF_SSID, 4'hf, $random(seed));
    irst = 1'b1;
    tick(1);
    irst = 1'b0;
    {m_le, m_ss} = '0;
    rd_reg(PLRE_OFF_PM);
    rd_reg(PLRE_OFF_SSID);
    wr_reg(PLRE_OFF_PM, 4'h2, 32'h8100);
    tick(3);
    check(wake_n, 1'b1);
    wr_reg(PLRE_OFF_SSID, 4'hf, $random(seed));
    wr_reg(PLRE_OFF_SSID_ALIAS, 4'h5, $random(seed));
    rd_reg(PLRE_OFF_SSID);
    rd_reg(PLRE_OFF_SSID_ALIAS);
    wr_reg(PLRE_OFF_LINK, 4'hf, 32'hffffffff);
    rd_reg(PLRE_OFF_LINK);
    {ld, eedat} = {1'b1, 32'h84};
    tick(1);
    ld = 1'b0;
    m_le = 32'h84;
    rd_reg(PLRE_OFF_LINK);
    // responses are not promoted while the enhancement gate is off
    {aresp, n_prio} = {1'b1, 32'd0};
    tick(1);
    {aresp, enh} = 2'b01;
    tick(4);
    check(n_prio, 0);
    aresp = 1'b1;
    tick(1);
    aresp = 1'b0;
    tick(4);
    check(n_prio, 1);
    {achg, aon, n_areq} = {2'b11, 32'd0};
    tick(1);
    achg = 1'b0;
    tick(4);
    check(n_areq, 0);
    wr_reg(PLRE_OFF_LINK, 4'h1, 32'h86);
    achg = 1'b1;
    tick(1);
    achg = 1'b0;
    tick(4);
    check(n_areq, 1);
    check(areq_on, 1'b1);
    // eight received bits leave the request alone, ten cancel it
    for (int n = 4; n < 6; n++) begin
      {want, rgo, rlen, n_cancel} = {2'b11, 4'(n), 32'd0};
      tick(1);
      rgo = 1'b0;
      tick(12);
      check(n_cancel != 0, n == 5);
    end
    ggo = 1'b1;
    tick(1);
    ggo = 1'b0;
    tick(8);
    check(c0, PLRE_CTL_IDLE);
    check(c1, PLRE_CTL_XMIT);
    want = 1'b0;
    tick(4);
    final_report();
  end
endmodule
`default_nettype wire
